/* rtl/bdc_pkg.sv */
// Package with register map, field layouts and decode functions.
package bdc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PRESET = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PINS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h18;

  // ****************************************************************
  // Field layouts and reset values
  // ****************************************************************
  localparam int CNT_W = 4;
  localparam int CTRL_W = 3;
  localparam int IRQ_N = 2;
  localparam int IRQ_TC = 0;
  localparam int IRQ_RIPPLE = 1;
  localparam int PIN_TC = 0;
  localparam int PIN_RC = 1;
  localparam logic [CNT_W-1:0] BCD_MIN = 4'h0;
  localparam logic [CNT_W-1:0] BCD_MAX = 4'h9;
  localparam logic [CNT_W-1:0] BCD_STEP = 4'h1;
  localparam logic [CNT_W-1:0] COUNT_RST = 4'h0;
  localparam logic [CNT_W-1:0] PRESET_RST = 4'h0;
  localparam logic [IRQ_N-1:0] IRQ_RST = 2'h0;

  typedef struct packed {
    logic async_load_n;
    logic down;
    logic count_en_n;
  } bdc_ctrl_t;

  localparam bdc_ctrl_t CTRL_RST = 3'h5;

  // ****************************************************************
  // Decode functions
  // ****************************************************************
  function automatic logic [CNT_W-1:0] bdc_next(
    input logic [CNT_W-1:0] v,
    input logic down
  );
    if (down) begin
      return (v == BCD_MIN) ? BCD_MAX : v - BCD_STEP;
    end
    return (v >= BCD_MAX) ? BCD_MIN : v + BCD_STEP;
  endfunction

  function automatic logic tc_decode(
    input logic [CNT_W-1:0] v,
    input logic down
  );
    return down ? (v == BCD_MIN) : (v == BCD_MAX);
  endfunction

endpackage

/* rtl/bdc_edge_sync.sv */
// Two-flop synchroniser with rising and falling edge pulses.
module bdc_edge_sync
  import bdc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  // ****************************************************************
  // Synchroniser and edge detector
  // ****************************************************************
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule

/* rtl/bdc_irq.sv */
// Sticky interrupt status with enable mask and clear strobe.
module bdc_irq
  import bdc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [IRQ_N-1:0] evt,
  input wire logic clr_wr,
  input wire logic en_wr,
  input wire logic [IRQ_N-1:0] wdata,
  output logic [IRQ_N-1:0] status,
  output logic [IRQ_N-1:0] enable,
  output logic irq
);

  // ****************************************************************
  // Status bits, set wins over clear
  // ****************************************************************
  logic [IRQ_N-1:0] status_q;
  logic [IRQ_N-1:0] enable_q;
  logic irq_q;

  genvar i;
  generate
    for (i = 0; i < IRQ_N; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rstn) begin
          status_q[i] <= 1'b0;
        end else if (evt[i]) begin
          status_q[i] <= 1'b1;
        end else if (clr_wr && wdata[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rstn) begin
      enable_q <= IRQ_RST;
    end else if (en_wr) begin
      enable_q <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & enable_q);
    end
  end

  assign status = status_q;
  assign enable = enable_q;
  assign irq = irq_q;

endmodule

/* rtl/bdc_counter.sv */
// Reversible BCD decade counter with preset, terminal count and APB.
// Operation
// (R1) Four-bit state counts in 8421 BCD, up or down.
// (R2) While load is low the preset value is copied into the count.
// (R3) Load overrides enable, direction and clock edges.
// (R4) Load high and enable high: count holds.
// (R5) Load high and enable low: one step per clock pulse rising edge.
// (R6) Direction low counts up, direction high counts down.
// (R7) Outside logic keeps setup and hold around the clock pulse edge.
// (R8) Terminal count is high at zero counting down or nine counting up.
// (R9) Terminal count holds until count or direction changes.
// (R10) Outside logic must not use terminal count as a clock.
// (R11) Ripple clock falls on falling pulse edge, rises on rising edge.
// (R12) Ripple clock stays high when enable is high or count not terminal.
// (R13) Up from nine wraps to zero, down from zero wraps to nine.
module bdc_counter
  import bdc_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  output logic [DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CLOCK_PULSE_IN,
  output logic [CNT_W-1:0] COUNT_VALUE_OUT,
  output logic TERMINAL_COUNT,
  output logic RIPPLE_CLOCK_N,
  output logic IRQ
);

  // ****************************************************************
  // Clock pulse input
  // ****************************************************************
  logic pulse_level;
  logic pulse_rise;
  logic pulse_fall;

  bdc_edge_sync u_sync (
    .clk(CLK),
    .rstn(RSTN),
    .pin(CLOCK_PULSE_IN), // [R7]
    .level(pulse_level),
    .rise(pulse_rise),
    .fall(pulse_fall)
  );

  // ****************************************************************
  // APB slave
  // ****************************************************************
  bdc_ctrl_t ctrl_q;
  bdc_ctrl_t ctrl_d;
  logic [CNT_W-1:0] preset_value_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic tc_q;
  logic rc_n_q;
  logic rc_n_d;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic pslverr_d;
  logic setup;
  logic access;
  logic wr;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_enable;
  logic [IRQ_N-1:0] irq_evt;
  logic irq_out;

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && pready_q;
  assign wr = access && PWRITE && !pslverr_q;

  always_comb begin
    prdata_d = '0;
    pslverr_d = 1'b0;
    case (PADDR)
      OFF_CTRL: prdata_d = {29'h0, ctrl_q};
      OFF_PRESET: prdata_d = {28'h0, preset_value_q};
      OFF_COUNT: begin
        prdata_d = {28'h0, count_q};
        pslverr_d = PWRITE;
      end
      OFF_PINS: begin
        prdata_d = {30'h0, rc_n_q, tc_q};
        pslverr_d = PWRITE;
      end
      OFF_IRQ_STAT: begin
        prdata_d = {30'h0, irq_status};
        pslverr_d = PWRITE;
      end
      OFF_IRQ_CLR: prdata_d = '0;
      OFF_IRQ_EN: prdata_d = {30'h0, irq_enable};
      default: pslverr_d = 1'b1;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && pslverr_d;
      if (setup && !PWRITE) begin
        prdata_q <= prdata_d;
      end
    end
  end

  // ****************************************************************
  // Control and preset registers
  // ****************************************************************
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr && PADDR == OFF_CTRL) begin
      ctrl_d = PWDATA[CTRL_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      preset_value_q <= PRESET_RST;
    end else if (wr && PADDR == OFF_PRESET) begin
      preset_value_q <= PWDATA[CNT_W-1:0];
    end
  end

  // ****************************************************************
  // Counter state
  // ****************************************************************
  always_comb begin
    count_d = count_q;
    if (!ctrl_q.async_load_n) begin
      count_d = preset_value_q; // [R2] [R3]
    end else if (!ctrl_q.count_en_n && pulse_rise) begin
      count_d = bdc_next(count_q, ctrl_q.down); // [R1] [R5] [R6] [R13]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      count_q <= COUNT_RST;
    end else begin
      count_q <= count_d; // [R4]
    end
  end

  // ****************************************************************
  // Terminal count and ripple clock
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      tc_q <= tc_decode(COUNT_RST, CTRL_RST.down);
    end else begin
      tc_q <= tc_decode(count_d, ctrl_d.down); // [R8] [R9]
    end
  end

  always_comb begin
    rc_n_d = rc_n_q;
    if (ctrl_q.count_en_n || !tc_q) begin
      rc_n_d = 1'b1; // [R12]
    end else if (pulse_fall) begin
      rc_n_d = 1'b0; // [R11]
    end else if (pulse_rise) begin
      rc_n_d = 1'b1; // [R11]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rc_n_q <= 1'b1;
    end else begin
      rc_n_q <= rc_n_d;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_TC] = !tc_q && tc_decode(count_d, ctrl_d.down);
    irq_evt[IRQ_RIPPLE] = rc_n_q && !rc_n_d;
  end

  bdc_irq u_irq (
    .clk(CLK),
    .rstn(RSTN),
    .evt(irq_evt),
    .clr_wr(wr && PADDR == OFF_IRQ_CLR),
    .en_wr(wr && PADDR == OFF_IRQ_EN),
    .wdata(PWDATA[IRQ_N-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq_out)
  );

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign COUNT_VALUE_OUT = count_q;
  assign TERMINAL_COUNT = tc_q;
  assign RIPPLE_CLOCK_N = rc_n_q;
  assign IRQ = irq_out;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  logic counting;
  assign counting = ctrl_q.async_load_n && !ctrl_q.count_en_n;

  chk_bcd_range: assert property ( // [R1]
    (ctrl_q.async_load_n && count_q <= BCD_MAX) |=> count_q <= BCD_MAX)
    else $error("count left the decade range");

  chk_load_copy: assert property ( // [R2]
    !ctrl_q.async_load_n ##1 !ctrl_q.async_load_n
    |-> COUNT_VALUE_OUT == $past(preset_value_q))
    else $error("count does not follow preset during load");

  chk_load_prio: assert property ( // [R3]
    (!ctrl_q.async_load_n && !ctrl_q.count_en_n && pulse_rise)
    |=> count_q == $past(preset_value_q))
    else $error("clock edge counted during load");

  chk_hold_idle: assert property ( // [R4]
    (ctrl_q.async_load_n && ctrl_q.count_en_n) |=> $stable(count_q))
    else $error("count changed while disabled");

  chk_step_edge: assert property ( // [R5]
    (counting && pulse_rise)
    |=> count_q == bdc_next($past(count_q), $past(ctrl_q.down)))
    else $error("count did not step on rising pulse");

  chk_no_edge: assert property ( // [R5]
    (ctrl_q.async_load_n && !pulse_rise) |=> $stable(count_q))
    else $error("count changed without a pulse edge");

  chk_dir_up: assert property ( // [R6]
    (counting && pulse_rise && !ctrl_q.down && count_q < BCD_MAX)
    |=> count_q == $past(count_q) + BCD_STEP)
    else $error("up count wrong");

  chk_dir_down: assert property ( // [R6]
    (counting && pulse_rise && ctrl_q.down && count_q > BCD_MIN
      && count_q <= BCD_MAX)
    |=> count_q == $past(count_q) - BCD_STEP)
    else $error("down count wrong");

  chk_tc_decode: assert property ( // [R8] [R9]
    TERMINAL_COUNT == (ctrl_q.down ? (count_q == BCD_MIN)
      : (count_q == BCD_MAX)))
    else $error("terminal count does not match state");

  chk_ripple_fall: assert property ( // [R11]
    (!ctrl_q.count_en_n && tc_q && pulse_fall) |=> !RIPPLE_CLOCK_N)
    else $error("ripple clock did not fall");

  chk_ripple_rise: assert property ( // [R11]
    pulse_rise |=> RIPPLE_CLOCK_N)
    else $error("ripple clock did not release");

  chk_ripple_gate: assert property ( // [R12]
    (ctrl_q.count_en_n || !tc_q) |=> RIPPLE_CLOCK_N)
    else $error("ripple clock low while gated off");

  chk_ripple_low: assert property ( // [R11]
    !RIPPLE_CLOCK_N |-> !$past(pulse_level))
    else $error("ripple clock low while pulse high");

  chk_ripple_hold: assert property ( // [R11]
    (!RIPPLE_CLOCK_N && !ctrl_q.count_en_n && tc_q && !pulse_rise)
    |=> !RIPPLE_CLOCK_N)
    else $error("ripple clock released early");

  chk_wrap_up: assert property ( // [R13]
    (counting && pulse_rise && !ctrl_q.down && count_q == BCD_MAX)
    |=> count_q == BCD_MIN)
    else $error("no wrap from nine to zero");

  chk_wrap_down: assert property ( // [R13]
    (counting && pulse_rise && ctrl_q.down && count_q == BCD_MIN)
    |=> count_q == BCD_MAX)
    else $error("no wrap from zero to nine");

  chk_apb_ready: assert property (
    setup |=> PREADY ##1 !PREADY)
    else $error("pready not a single access cycle");

  chk_apb_unmapped: assert property (
    (setup && PADDR > OFF_IRQ_EN) |=> PSLVERR)
    else $error("unmapped access not refused");

  chk_ro_write: assert property (
    (setup && PWRITE && PADDR == OFF_COUNT) |=> PSLVERR && PREADY)
    else $error("write to count not refused");

  chk_err_ready: assert property (
    PSLVERR |-> PREADY)
    else $error("error shown without ready");

  logic irq_pend;
  assign irq_pend = |(irq_status & irq_enable);

  chk_irq_level: assert property (
    IRQ == $past(irq_pend))
    else $error("interrupt level does not follow status");

  chk_irq_set: assert property (
    (irq_evt != '0)
    |=> (irq_status & $past(irq_evt)) == $past(irq_evt))
    else $error("event did not set status");

  chk_irq_sticky: assert property (
    (irq_status != '0 && !(wr && PADDR == OFF_IRQ_CLR))
    |=> (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("status bit lost without clear");

  cov_wrap_up: cover property (
    counting && pulse_rise && !ctrl_q.down && count_q == BCD_MAX);
  cov_wrap_down: cover property (
    counting && pulse_rise && ctrl_q.down && count_q == BCD_MIN);
  cov_ripple: cover property (RIPPLE_CLOCK_N ##1 !RIPPLE_CLOCK_N);
  cov_irq: cover property (!IRQ ##1 IRQ);
  cov_load: cover property (!ctrl_q.async_load_n ##1 ctrl_q.async_load_n);

endmodule

/* tb/bdc_pulse_src.sv */
// Partner model: outside logic that drives the counting clock pin.
module bdc_pulse_src
(
  input wire logic clk,
  input wire logic go,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] cnt_q;

  // ****************************************************************
  // Pulse shaping
  // ****************************************************************
  // One pulse on each request: high five cycles, then low six cycles.
  // The terminal count output is never used as a clock here.
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    cnt_q = 4'h0;
  end

  always @(posedge clk) begin
    if (!busy && go) begin
      busy <= 1'b1;
      cnt_q <= 4'h0;
      pin <= 1'b1;
    end else if (busy) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'h4) begin
        pin <= 1'b0;
      end
      if (cnt_q == 4'ha) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

/* tb/bcd_updown_decade_counter_tb.sv */
// Testbench for the reversible decade counter with register access.
module bcd_updown_decade_counter_tb import bdc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rstn, psel, penable, pwrite, pulse_go, pulse_pin, pulse_busy;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic pready, pslverr, tc, rc_n, irq, er;
  logic [CNT_W-1:0] count;
  int n_errors, cmp_count;

  // ****************************************************************
  // Instances
  // ****************************************************************
  bdc_counter DUT (.CLK(clk), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CLOCK_PULSE_IN(pulse_pin), .COUNT_VALUE_OUT(count),
    .TERMINAL_COUNT(tc), .RIPPLE_CLOCK_N(rc_n), .IRQ(irq));

  bdc_pulse_src u_src (.clk(clk), .go(pulse_go), .pin(pulse_pin),
    .busy(pulse_busy));

  always #5 clk = ~clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task end_of_test;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [DATA_W-1:0] exp,
    input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task apb(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task pulse(input int n);
    int i;
    int k;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      pulse_go <= 1'b1;
      @(posedge clk);
      pulse_go <= 1'b0;
      for (k = 0; k < 40; k++) begin
        @(posedge clk);
        if (pulse_busy !== 1'b1) break;
      end
      if (k == 40) begin
        n_errors++;
        end_of_test();
      end
    end
    idle(2);
  endtask

  task pins(input logic [CNT_W-1:0] c, input logic t, input logic r);
    chk("count", {28'h0, c}, {28'h0, count});
    chk("terminal", {31'h0, t}, {31'h0, tc});
    chk("ripple", {31'h0, r}, {31'h0, rc_n});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl", {29'h0, CTRL_RST}, rd);
    apb(1'b0, OFF_PRESET, 32'h0);
    chk("preset", 32'h0, rd);
    apb(1'b0, OFF_PINS, 32'h0);
    chk("pins", 32'h2, rd);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    chk("stat", 32'h0, rd);
  endtask

  task t_refuse;
    apb(1'b1, OFF_COUNT, 32'h3);
    chk("ro_err", 32'h1, {31'h0, er});
    chk("count", 32'h0, {28'h0, count});
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
  endtask

  task t_load;
    apb(1'b1, OFF_PRESET, 32'h3);
    apb(1'b1, OFF_CTRL, 32'h0);
    pulse(1);
    pins(4'h3, 1'b0, 1'b1);
    apb(1'b1, OFF_PRESET, 32'h8);
    idle(2);
    pins(4'h8, 1'b0, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h5);
    pulse(2);
    pins(4'h8, 1'b0, 1'b1);
  endtask

  task t_up;
    apb(1'b1, OFF_CTRL, 32'h4);
    pulse(1);
    pins(4'h9, 1'b1, 1'b0);
    apb(1'b1, OFF_CTRL, 32'h5);
    idle(3);
    pins(4'h9, 1'b1, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h4);
    pulse(1);
    pins(4'h0, 1'b0, 1'b1);
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("count_reg", 32'h0, rd);
  endtask

  task t_down;
    apb(1'b1, OFF_CTRL, 32'h6);
    idle(3);
    pins(4'h0, 1'b1, 1'b1);
    pulse(1);
    pins(4'h9, 1'b0, 1'b1);
    pulse(1);
    pins(4'h8, 1'b0, 1'b1);
  endtask

  task t_irq;
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    chk("stat", 32'h3, rd);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFF_IRQ_EN, 32'h1);
    idle(2);
    chk("irq_tc", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_IRQ_CLR, 32'h1);
    idle(2);
    chk("irq_clr", 32'h0, {31'h0, irq});
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    chk("stat_clr", 32'h2, rd);
    apb(1'b1, OFF_IRQ_EN, 32'h2);
    idle(2);
    chk("irq_rc", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_IRQ_CLR, 32'h2);
    idle(2);
    chk("irq_off", 32'h0, {31'h0, irq});
    apb(1'b0, OFF_IRQ_CLR, 32'h0);
    chk("clr_read", 32'h0, rd);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pulse_go = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    idle(1);
    t_reset();
    t_refuse();
    t_load();
    t_up();
    t_down();
    t_irq();
    end_of_test();
  end
endmodule
